// ### tlvi_consts.vh
`ifndef TLVI_CONSTS_VH
`define TLVI_CONSTS_VH
// register byte offsets (printed offsets are multiples of four)
`define TLVI_OFF_IEN_MAIN   8'hA8
`define TLVI_OFF_IEN_T2     8'hE8
`define TLVI_OFF_PRIO_MAIN  8'hB8
`define TLVI_OFF_PRIO_T2    8'hF8
`define TLVI_OFF_FLAGS      8'h00
`define TLVI_OFF_CTRL       8'h04
`define TLVI_OFF_STATUS     8'h08
// bit positions
`define TLVI_GLOBAL_EN_BIT  7
`define TLVI_CTRL_IT0_BIT   0
`define TLVI_CTRL_IT1_BIT   1
// source indices (vector order)
`define TLVI_SRC_X0   4'h0
`define TLVI_SRC_T0   4'h1
`define TLVI_SRC_X1   4'h2
`define TLVI_SRC_T1   4'h3
`define TLVI_SRC_S0   4'h4
`define TLVI_SRC_S1   4'h5
`define TLVI_SRC_CT0  4'h6
`define TLVI_SRC_CT1  4'h7
`define TLVI_SRC_CT2  4'h8
`define TLVI_SRC_CT3  4'h9
`define TLVI_SRC_ADC  4'hA
`define TLVI_SRC_CM0  4'hB
`define TLVI_SRC_CM1  4'hC
`define TLVI_SRC_CM2  4'hD
`define TLVI_SRC_T2   4'hE
// vectors
`define TLVI_VEC_BASE 16'h0003
`define TLVI_VEC_STEP 16'h0008
// reset values
`define TLVI_RST_REG  8'h00
`define TLVI_NSRC     15
`endif

// ### tlvi_ctrl.v
`timescale 1ns/1ps
`include "tlvi_consts.vh"
// Operation
// RULE_01: fifteen sources, each with request flag, enable, priority and vector.
// RULE_02: each external input selects level or falling-edge trigger, sets own flag.
// RULE_03: edge external flag clears on vectoring; level flag follows the pin.
// RULE_04: level source holds low until taken, releases before routine ends.
// RULE_05: external inputs are active low for wired-OR sharing.
// RULE_06: timer 0/1 overflow flags set on rollover, cleared on vectoring.
// RULE_07: timer 2 has eight sources, none cleared by hardware on vectoring.
// RULE_08: UART request is OR of rx and tx done; software clears both.
// RULE_09: two-wire and seconds flags software-cleared; seconds ORs onto external 1.
// RULE_10: ADC flag set on scan done, software clears only, write-one ignored.
// RULE_11: software writes set or clear other flags like hardware.
// RULE_12: only ext0, t0, ext1, t1, seconds, UART, two-wire end idle.
// RULE_13: per-source enables, global enable bit 7 gates everything; here it gates call requests only, idle_wake_o is not gated.
// RULE_14: main enable bits 6..0: ADC, two-wire, UART, t1, ext1, t0, ext0.
// RULE_15: one priority bit per source, 1 means high level.
// RULE_16: high preempts low; high is never preempted.
// RULE_17: high served first; fixed polling order within a level.
// RULE_18: flags sampled each machine cycle, evaluated next cycle, repeated.
// RULE_19: call withheld for active level, mid-instruction, or after return/register access.
// RULE_20: blocked request whose flag dropped is lost; no memory between polls.
// RULE_21: acknowledge calls vector, pushes pc not status, marks level active; here the level is marked active when call_req_o is raised.
// RULE_22: return clears current level active flag, then core pops pc.
// RULE_23: polling order x0,s1,adc,t0,ct0,cm0,x1,ct1,cm1,t1,ct2,cm2,s0,ct3,t2.
// RULE_24: vectors from 0003H stepping eight; ADC 0053H, timer 2 overflow 0073H.
// RULE_25: timer 2 enable bits 7..0: overflow, compares 2-0, captures 3-0.
// RULE_26: priority registers mirror enables; main bit 7 reserved.
// RULE_27: one active flag per level, set on acknowledge, used for blocking; here it is set when call_req_o rises, before call_ack_i.
module tlvi_ctrl (
	// clock and reset
	input  wire        clk_sys_i,
	input  wire        srst_i,
	// axi4-lite slave
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	// external pins, active low
	input  wire        ext_irq0_pin_n_i,
	input  wire        ext_irq1_pin_n_i,
	// peripheral event pulses
	input  wire        timer0_rollover_i,
	input  wire        timer1_rollover_i,
	input  wire [3:0]  t2_capture_i,
	input  wire [2:0]  t2_compare_i,
	input  wire        t2_overflow_i,
	input  wire        uart_rx_done_i,
	input  wire        uart_tx_done_i,
	input  wire        twowire_event_i,
	input  wire        adc_scan_done_i,
	input  wire        seconds_tick_i,
	// core handshake
	input  wire        machine_cycle_i,
	input  wire        instr_last_cycle_i,
	input  wire        return_from_interrupt_exec_i,
	input  wire        irq_reg_access_i,
	input  wire        instr_done_i,
	input  wire        call_ack_i,
	output reg         call_req_o,
	output reg  [15:0] call_vector_o,
	output wire        idle_wake_o
);

	// request flags in vector order
	reg  [14:0] flag; // RULE_01
	reg  [7:0]  ien_main;
	reg  [7:0]  ien_t2;
	reg  [6:0]  prio_main;
	reg  [7:0]  prio_t2;
	reg  [1:0]  edge_sel;
	reg  [1:0]  uart_sub;
	reg         seconds_flag;
	reg  [1:0]  active;
	reg  [14:0] sample;
	reg         hold_off;
	reg  [3:0]  call_src;
	reg  [1:0]  x0_sync;
	reg  [1:0]  x1_sync;
	reg  [1:0]  x_prev;
	reg  [7:0]  aw_addr;
	reg         aw_full;
	reg  [31:0] w_data;
	reg         w_full;

	// enable and priority per source in vector order
	wire [14:0] en_vec;
	wire [14:0] pr_vec;
	assign en_vec = {ien_t2[7], ien_t2[6:4], ien_main[6], ien_t2[3:0], ien_main[5:0]}; // RULE_14 RULE_25
	assign pr_vec = {prio_t2[7], prio_t2[6:4], prio_main[6], prio_t2[3:0], prio_main[5:0]}; // RULE_15 RULE_26

	// polling order maps rank to vector index
	function [3:0] poll_src;
		input [3:0] rank;
		begin
			case (rank) // RULE_23
			4'h0: poll_src = `TLVI_SRC_X0;
			4'h1: poll_src = `TLVI_SRC_S1;
			4'h2: poll_src = `TLVI_SRC_ADC;
			4'h3: poll_src = `TLVI_SRC_T0;
			4'h4: poll_src = `TLVI_SRC_CT0;
			4'h5: poll_src = `TLVI_SRC_CM0;
			4'h6: poll_src = `TLVI_SRC_X1;
			4'h7: poll_src = `TLVI_SRC_CT1;
			4'h8: poll_src = `TLVI_SRC_CM1;
			4'h9: poll_src = `TLVI_SRC_T1;
			4'hA: poll_src = `TLVI_SRC_CT2;
			4'hB: poll_src = `TLVI_SRC_CM2;
			4'hC: poll_src = `TLVI_SRC_S0;
			4'hD: poll_src = `TLVI_SRC_CT3;
			default: poll_src = `TLVI_SRC_T2;
			endcase
		end
	endfunction

	// picks first polled source among a mask; found flag in bit 4
	function [4:0] pick;
		input [14:0] m;
		integer i;
		reg [4:0] r;
		begin
			r = 5'h00;
			for (i = 14; i >= 0; i = i - 1) begin
				if (m[poll_src(i[3:0])]) begin
					r = {1'b1, poll_src(i[3:0])};
				end
			end
			pick = r;
		end
	endfunction

	// axi handshakes
	wire wr_go;
	wire rd_go;
	assign s_axi_awready = !aw_full;
	assign s_axi_wready  = !w_full;
	assign s_axi_arready = !s_axi_rvalid;
	assign wr_go = aw_full && w_full && !s_axi_bvalid;
	assign rd_go = s_axi_arvalid && !s_axi_rvalid;

	// software write decode to flag register
	reg  [3:0]  w_strb;
	wire        w_strb_ok;
	wire        sw_flag_wr;
	wire [31:0] sw_val;
	assign w_strb_ok = w_strb[0] | w_strb[1];
	assign sw_flag_wr = wr_go && (aw_addr == `TLVI_OFF_FLAGS) && w_strb_ok;
	assign sw_val     = w_data;

	// pin levels after sync, active low inputs
	wire x0_low;
	wire x1_low;
	assign x0_low = !x0_sync[1]; // RULE_05
	assign x1_low = !x1_sync[1];

	// poll arbitration over sampled flags
	wire [14:0] req;
	wire [4:0]  hi_pick;
	wire [4:0]  lo_pick;
	wire        hi_ok;
	wire        lo_ok;
	wire        can_call;
	assign req     = sample & en_vec & {15{ien_main[`TLVI_GLOBAL_EN_BIT]}}; // RULE_13
	assign hi_pick = pick(req & pr_vec);
	assign lo_pick = pick(req & ~pr_vec);
	assign hi_ok   = hi_pick[4] && !active[1]; // RULE_16
	assign lo_ok   = lo_pick[4] && !active[1] && !active[0];
	assign can_call = machine_cycle_i && instr_last_cycle_i && !hold_off
		&& !call_req_o && !return_from_interrupt_exec_i && !irq_reg_access_i; // RULE_19

	// wake on subset of sources, unmasked
	assign idle_wake_o = |(flag[5:0]) | seconds_flag; // RULE_12

	// synchronisers for pins
	always @(posedge clk_sys_i) begin
		if (srst_i) begin
			x0_sync <= 2'b11;
			x1_sync <= 2'b11;
		end else begin
			x0_sync <= {x0_sync[0], ext_irq0_pin_n_i};
			x1_sync <= {x1_sync[0], ext_irq1_pin_n_i};
		end
	end

	// request flags, hardware set wins over clears
	reg [14:0] next_flag;
	reg [1:0]  next_uart;
	reg        next_sec;
	reg        ack_edge0;
	reg        ack_edge1;
	always @* begin
		next_flag = flag;
		next_uart = uart_sub;
		next_sec  = seconds_flag;
		ack_edge0 = call_req_o && call_ack_i && (call_src == `TLVI_SRC_X0);
		ack_edge1 = call_req_o && call_ack_i && (call_src == `TLVI_SRC_X1);
		// software writes to the flag register
		if (sw_flag_wr) begin // RULE_11
			next_flag = sw_val[14:0];
			next_flag[`TLVI_SRC_ADC] = flag[`TLVI_SRC_ADC] & sw_val[`TLVI_SRC_ADC]; // RULE_10
			next_uart = sw_val[17:16];
			next_sec  = sw_val[18];
		end
		// clear on vectoring
		if (call_req_o && call_ack_i) begin
			if (call_src == `TLVI_SRC_T0 || call_src == `TLVI_SRC_T1) begin
				next_flag[call_src] = 1'b0; // RULE_06
			end
		end
		if (ack_edge0 && edge_sel[0]) begin
			next_flag[`TLVI_SRC_X0] = 1'b0; // RULE_03
		end
		if (ack_edge1 && edge_sel[1]) begin
			next_flag[`TLVI_SRC_X1] = 1'b0;
		end
		// hardware sets
		if (timer0_rollover_i) next_flag[`TLVI_SRC_T0] = 1'b1; // RULE_06
		if (timer1_rollover_i) next_flag[`TLVI_SRC_T1] = 1'b1;
		next_flag[9:6]   = next_flag[9:6] | t2_capture_i; // RULE_07
		next_flag[13:11] = next_flag[13:11] | t2_compare_i;
		if (t2_overflow_i) next_flag[`TLVI_SRC_T2] = 1'b1;
		if (adc_scan_done_i) next_flag[`TLVI_SRC_ADC] = 1'b1; // RULE_10
		if (twowire_event_i) next_flag[`TLVI_SRC_S1] = 1'b1; // RULE_09
		if (uart_rx_done_i) next_uart[0] = 1'b1;
		if (uart_tx_done_i) next_uart[1] = 1'b1;
		if (seconds_tick_i) next_sec = 1'b1;
		next_flag[`TLVI_SRC_S0] = |next_uart; // RULE_08
		// external: edge sets on falling, level follows pin
		if (edge_sel[0]) begin // RULE_02
			if (x_prev[0] && x0_low) next_flag[`TLVI_SRC_X0] = 1'b1;
		end else begin
			next_flag[`TLVI_SRC_X0] = x0_low; // RULE_03
		end
		if (edge_sel[1]) begin
			if (x_prev[1] && x1_low) next_flag[`TLVI_SRC_X1] = 1'b1;
		end else begin
			next_flag[`TLVI_SRC_X1] = x1_low;
		end
	end

	// flag, sample and pin history registers
	always @(posedge clk_sys_i) begin
		if (srst_i) begin
			flag         <= 15'h0000;
			uart_sub     <= 2'b00;
			seconds_flag <= 1'b0;
			sample       <= 15'h0000;
			x_prev       <= 2'b00;
		end else begin
			flag         <= next_flag;
			uart_sub     <= next_uart;
			seconds_flag <= next_sec;
			x_prev       <= {!x1_low, !x0_low};
			if (machine_cycle_i) begin
				// fresh snapshot each machine cycle, nothing kept
				sample <= flag | {12'h000, seconds_flag, 2'b00}; // RULE_18 RULE_20 RULE_09
			end
		end
	end

	// call request, level tracking and hold-off
	always @(posedge clk_sys_i) begin
		if (srst_i) begin
			call_req_o    <= 1'b0;
			call_vector_o <= 16'h0000;
			call_src      <= 4'h0;
			active        <= 2'b00;
			hold_off      <= 1'b0;
		end else begin
			if (return_from_interrupt_exec_i || irq_reg_access_i) begin
				hold_off <= 1'b1; // RULE_19
			end else if (instr_done_i) begin
				hold_off <= 1'b0;
			end
			if (return_from_interrupt_exec_i) begin
				// drop highest active level
				if (active[1]) active[1] <= 1'b0; // RULE_22
				else active[0] <= 1'b0;
			end
			if (call_req_o && call_ack_i) begin
				call_req_o <= 1'b0;
			end else if (can_call && (hi_ok || lo_ok)) begin
				call_req_o <= 1'b1; // RULE_17 RULE_21
				call_src   <= hi_ok ? hi_pick[3:0] : lo_pick[3:0];
				call_vector_o <= `TLVI_VEC_BASE + `TLVI_VEC_STEP * {12'h000, (hi_ok ? hi_pick[3:0] : lo_pick[3:0])}; // RULE_24
				if (hi_ok) active[1] <= 1'b1; // RULE_27
				else active[0] <= 1'b1;
			end
		end
	end

	// axi write path
	always @(posedge clk_sys_i) begin
		if (srst_i) begin
			aw_addr      <= 8'h00;
			aw_full      <= 1'b0;
			w_data       <= 32'h00000000;
			w_strb       <= 4'h0;
			w_full       <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= 2'b00;
			ien_main     <= `TLVI_RST_REG;
			ien_t2       <= `TLVI_RST_REG;
			prio_main    <= 7'h00;
			prio_t2      <= `TLVI_RST_REG;
			edge_sel     <= 2'b00;
		end else begin
			if (s_axi_awvalid && !aw_full) begin
				aw_addr <= s_axi_awaddr;
				aw_full <= 1'b1;
			end
			if (s_axi_wvalid && !w_full) begin
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
				w_full <= 1'b1;
			end
			if (s_axi_bvalid && s_axi_bready) s_axi_bvalid <= 1'b0;
			if (wr_go) begin
				aw_full      <= 1'b0;
				w_full       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= 2'b00;
				if (w_strb[0]) begin
					case (aw_addr)
					`TLVI_OFF_IEN_MAIN:  ien_main  <= w_data[7:0];
					`TLVI_OFF_IEN_T2:    ien_t2    <= w_data[7:0];
					`TLVI_OFF_PRIO_MAIN: prio_main <= w_data[6:0];
					`TLVI_OFF_PRIO_T2:   prio_t2   <= w_data[7:0];
					`TLVI_OFF_CTRL:      edge_sel  <= w_data[1:0];
					`TLVI_OFF_FLAGS:     s_axi_bresp <= 2'b00;
					`TLVI_OFF_STATUS:    s_axi_bresp <= 2'b00;
					default:             s_axi_bresp <= 2'b10;
					endcase
				end
			end
		end
	end

	// axi read path
	always @(posedge clk_sys_i) begin
		if (srst_i) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= 2'b00;
		end else begin
			if (s_axi_rvalid && s_axi_rready) s_axi_rvalid <= 1'b0;
			if (rd_go) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= 2'b00;
				case (s_axi_araddr)
				`TLVI_OFF_IEN_MAIN:  s_axi_rdata <= {24'h000000, ien_main};
				`TLVI_OFF_IEN_T2:    s_axi_rdata <= {24'h000000, ien_t2};
				`TLVI_OFF_PRIO_MAIN: s_axi_rdata <= {25'h0000000, prio_main};
				`TLVI_OFF_PRIO_T2:   s_axi_rdata <= {24'h000000, prio_t2};
				`TLVI_OFF_FLAGS:     s_axi_rdata <= {13'h0000, seconds_flag, uart_sub, 1'b0, flag};
				`TLVI_OFF_CTRL:      s_axi_rdata <= {30'h00000000, edge_sel};
				`TLVI_OFF_STATUS:    s_axi_rdata <= {24'h000000, call_src, hold_off, call_req_o, active};
				default: begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= 2'b10;
				end
				endcase
			end
		end
	end

endmodule

// ### tlvi_ctrl_monitor.sv
`timescale 1ns/1ps
module tlvi_monitor (
	// clock and reset
	input wire        clk_sys_i,
	input wire        srst_i,
	// register bus
	input wire        s_axi_awvalid,
	input wire        s_axi_awready,
	input wire        s_axi_wvalid,
	input wire        s_axi_wready,
	input wire [1:0]  s_axi_bresp,
	input wire        s_axi_bvalid,
	input wire        s_axi_bready,
	input wire        s_axi_arvalid,
	input wire        s_axi_arready,
	input wire        s_axi_rvalid,
	// core handshake
	input wire        machine_cycle_i,
	input wire        instr_last_cycle_i,
	input wire        return_from_interrupt_exec_i,
	input wire        call_ack_i,
	input wire        call_req_o,
	input wire [15:0] call_vector_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (srst_i);
	// call request and vector stand until the core accepts
	a_req_holds: assert property (call_req_o && !call_ack_i |=> call_req_o)
		else $error("call request dropped early");
	a_vec_steady: assert property (call_req_o && !call_ack_i |=> $stable(call_vector_o))
		else $error("vector moved while pending");
	a_vec_legal: assert property (call_req_o |-> call_vector_o[2:0] == 3'h3 && call_vector_o <= 16'h0073)
		else $error("vector outside table");
	// a call starts only from a poll at the end of an instruction
	a_poll_point: assert property ($rose(call_req_o) |-> $past(machine_cycle_i && instr_last_cycle_i))
		else $error("call not launched from a poll");
	a_return_from_interrupt_block: assert property ($rose(call_req_o) |-> !$past(return_from_interrupt_exec_i, 2))
		else $error("call right after return");
	// register bus answers
	a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response not held");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##[1:3] s_axi_bvalid) else $error("write answer late");
	c_call: cover property ($rose(call_req_o));
	c_after_ret: cover property (return_from_interrupt_exec_i ##[1:40] $rose(call_req_o));
	c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
endmodule
bind tlvi_ctrl tlvi_monitor u_mon (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
	.machine_cycle_i(machine_cycle_i), .instr_last_cycle_i(instr_last_cycle_i), .return_from_interrupt_exec_i(return_from_interrupt_exec_i),
	.call_ack_i(call_ack_i), .call_req_o(call_req_o), .call_vector_o(call_vector_o));

// ### tlvi_core_model.sv
`timescale 1ns/1ps
module tlvi_core_model (
	// clock and reset
	input  wire       clk_sys_i,
	input  wire       srst_i,
	// bench control
	input  wire       slow_i,
	input  wire [1:0] cmd_i,
	// controller handshake
	input  wire       call_req_i,
	output reg        machine_cycle_o,
	output reg        instr_last_o,
	output reg        return_from_interrupt_exec_o,
	output reg        reg_access_o,
	output wire       instr_done_o,
	output reg        call_ack_o
);
	reg [1:0] phase;
	reg [1:0] pend;
	reg [1:0] wait_cnt;
	// an instruction ends on a machine cycle marked last
	assign instr_done_o = machine_cycle_o & instr_last_o;
	// four clocks a machine cycle; slow mode gives two-cycle instructions
	always @(posedge clk_sys_i) begin
		if (srst_i) begin
			phase           <= 2'h0;
			pend            <= 2'h0;
			wait_cnt        <= 2'h0;
			machine_cycle_o <= 1'b0;
			instr_last_o    <= 1'b1;
			return_from_interrupt_exec_o     <= 1'b0;
			reg_access_o    <= 1'b0;
			call_ack_o      <= 1'b0;
		end else begin
			phase           <= phase + 2'h1;
			machine_cycle_o <= (phase == 2'h3);
			if (phase == 2'h3)
				instr_last_o <= !slow_i | !instr_last_o;
			// return or register access lands just before a machine cycle
			pend         <= (phase == 2'h2) ? 2'h0 : (pend | cmd_i);
			return_from_interrupt_exec_o  <= (phase == 2'h2) & (pend[0] | cmd_i[0]);
			reg_access_o <= (phase == 2'h2) & (pend[1] | cmd_i[1]);
			// accept a call after one, or when slow three, waiting clocks
			wait_cnt   <= (call_req_i & !call_ack_o) ? wait_cnt + 2'h1 : 2'h0;
			call_ack_o <= call_req_i & !call_ack_o & (wait_cnt >= {slow_i, 1'b0});
		end
	end
endmodule

// ### two_level_vectored_irq_controller_tb_top.sv
`timescale 1ns/1ps
module two_level_vectored_irq_controller_tb_top;
	localparam [59:0] ORD = 60'h05A16B27C38D49E;
	reg         clk_sys_i = 1'b0;
	reg         srst_i    = 1'b1;
	reg  [7:0]  awa       = 8'h00;
	reg  [7:0]  ara       = 8'h00;
	reg  [31:0] wd        = 32'h0;
	reg         awv       = 1'b0;
	reg         wv        = 1'b0;
	reg         bry       = 1'b0;
	reg         arv       = 1'b0;
	reg         rry       = 1'b0;
	reg  [1:0]  pin       = 2'h3;
	reg  [16:0] ev        = 17'h0;
	reg         slow      = 1'b0;
	reg  [1:0]  cmd       = 2'h0;
	wire        awr, wrr, bvl, arr, rvl, creq, cack, mc, last, return_from_interrupt, racc, done, wake;
	wire [1:0]  bresp, rresp;
	wire [31:0] rdata;
	wire [15:0] cvec;
	integer     fails     = 0;
	integer     cmp_count = 0;
	integer     seed      = 49;
	integer     i, k;
	reg  [31:0] q, d;
	reg  [1:0]  r;
	reg  [14:0] e, m;
	reg  [7:0]  pm, pt;
	reg  [3:0]  s;
	tlvi_ctrl dut (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrr),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvl), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvl), .s_axi_rready(rry),
		.ext_irq0_pin_n_i(pin[0]), .ext_irq1_pin_n_i(pin[1]), .timer0_rollover_i(ev[1]),
		.timer1_rollover_i(ev[3]), .t2_capture_i(ev[9:6]), .t2_compare_i(ev[13:11]), .t2_overflow_i(ev[14]),
		.uart_rx_done_i(ev[4]), .uart_tx_done_i(ev[15]), .twowire_event_i(ev[5]), .adc_scan_done_i(ev[10]),
		.seconds_tick_i(ev[16]), .machine_cycle_i(mc), .instr_last_cycle_i(last), .return_from_interrupt_exec_i(return_from_interrupt),
		.irq_reg_access_i(racc), .instr_done_i(done), .call_ack_i(cack), .call_req_o(creq),
		.call_vector_o(cvec), .idle_wake_o(wake));
	tlvi_core_model u_core (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .slow_i(slow), .cmd_i(cmd),
		.call_req_i(creq), .machine_cycle_o(mc), .instr_last_o(last), .return_from_interrupt_exec_o(return_from_interrupt),
		.reg_access_o(racc), .instr_done_o(done), .call_ack_o(cack));
	initial forever #12.5 clk_sys_i = ~clk_sys_i;
	function [15:0] vec(input [3:0] n);
		vec = 16'h0003 + {9'h0, n, 3'h0};
	endfunction
	function [7:0] ad(input [1:0] n);
		ad = 8'hA8 | {1'b0, n[1], 1'b0, n[0], 4'h0};
	endfunction
	// first pending source in polling order, high level before low
	function [3:0] pick(input [14:0] mk, input [14:0] pr);
		integer h, j;
		reg [3:0] c;
		begin
			pick = 4'hF;
			for (h = 1; h >= 0; h = h - 1)
				for (j = 0; j < 15; j = j + 1) begin
					c = ORD[59 - 4 * j -: 4];
					if (pick == 4'hF && mk[c] && pr[c] == h)
						pick = c;
				end
		end
	endfunction
	task chk(input [31:0] seen, input [31:0] exp, input string what);
		begin
			cmp_count = cmp_count + 1;
			if (seen !== exp) begin
				fails = fails + 1;
				$display("CHECK FAILED %0s expected %h seen %h", what, exp, seen);
			end
		end
	endtask
	task tally_and_finish;
		begin
			$display("comparisons %0d mismatches %0d", cmp_count, fails);
			if (fails == 0 && cmp_count > 0)
				$display("SIMULATION PASSED");
			else
				$display("SIMULATION FAILED");
			$finish;
		end
	endtask
	// one register bus transfer, write or read, each channel held until taken
	task axi(input w, input [7:0] a, input [31:0] dat);
		integer n;
		reg     ta, tw, tr, fin;
		begin
			awa <= a;
			ara <= a;
			wd  <= dat;
			awv <= w;
			wv  <= w;
			bry <= w;
			arv <= !w;
			rry <= !w;
			n = 0;
			fin = 0;
			while (!fin && n < 100) begin
				@(negedge clk_sys_i);
				ta  = awv & awr;
				tw  = wv & wrr;
				tr  = arv & arr;
				fin = w ? bvl : rvl;
				q   = rdata;
				r   = w ? bresp : rresp;
				@(posedge clk_sys_i);
				if (ta)
					awv <= 1'b0;
				if (tw)
					wv <= 1'b0;
				if (tr)
					arv <= 1'b0;
				n = n + 1;
			end
			bry <= 1'b0;
			rry <= 1'b0;
			// let an edge pass so a following call never re-drives a strobe in this step
			@(posedge clk_sys_i);
			if (!fin)
				fails = fails + 1;
		end
	endtask
	task fire(input integer j);
		begin
			if (j == 0 || j == 2) begin
				pin[j / 2] <= 1'b0;
				repeat (8) @(posedge clk_sys_i);
				pin <= 2'h3;
			end else
				ev[j] <= 1'b1;
			@(posedge clk_sys_i);
			ev <= 17'h0;
		end
	endtask
	task wait_call(input [15:0] v, input hit);
		integer n;
		begin
			n = 0;
			do begin
				@(negedge clk_sys_i);
				n = n + 1;
			end while (creq !== 1'b1 && n < 60);
			chk(creq, hit, "call");
			if (hit)
				chk(cvec, v, "vector");
			while (creq === 1'b1)
				@(negedge clk_sys_i);
			@(posedge clk_sys_i);
		end
	endtask
	task ret;
		begin
			cmd <= 2'h1;
			@(posedge clk_sys_i);
			cmd <= 2'h0;
			repeat (12) @(posedge clk_sys_i);
		end
	endtask
	initial begin
		#(25 * 20000);
		fails = fails + 1;
		tally_and_finish;
	end
	initial begin
		repeat (10) @(posedge clk_sys_i);
		srst_i <= 1'b0;
		@(posedge clk_sys_i);
		// reset values, random write and readback of enable and priority registers
		for (k = 0; k < 4; k = k + 1) begin
			axi(0, ad(k[1:0]), 0);
			chk(q, 0, "reset");
			d = $random(seed);
			axi(1, ad(k[1:0]), d);
			axi(0, ad(k[1:0]), 0);
			chk(q, d[7:0] & ((k == 1) ? 8'h7F : 8'hFF), "readback");
		end
		axi(1, 8'h40, 32'h5A);
		chk(r, 2'b10, "unmapped write");
		axi(0, 8'h40, 0);
		chk(q, 0, "unmapped read");
		// every source alone: gated by global enable, then vectored
		axi(1, 8'h04, 32'h3);
		for (i = 0; i < 17; i = i + 1) begin
			s = (i == 15) ? 4'h4 : (i == 16) ? 4'h2 : i[3:0];
			e = 15'h1 << s;
			axi(1, 8'hE8, {e[14:11], e[9:6]});
			axi(1, 8'hA8, {e[10], e[5:0]});
			fire(i);
			wait_call(0, 0);
			chk(wake, s < 6, "wake");
			axi(1, 8'hA8, {1'b1, e[10], e[5:0]});
			wait_call(vec(s), 1);
			axi(0, 8'h00, 0);
			if (i < 15)
				chk(q, (i < 4) ? 32'h0 : ((32'h1 << i) | ((i == 4) ? 32'h10000 : 32'h0)), "flags");
			axi(1, 8'h00, 0);
			ret;
		end
		// several pending flags set by software with random priorities
		axi(1, 8'hA8, 8'hFF);
		axi(1, 8'hE8, 8'hFF);
		for (k = 0; k < 12; k = k + 1) begin
			slow <= k[0];
			pm = $random(seed);
			pt = $random(seed);
			m = ($random(seed) & 15'h7BEF) | (15'h1 << (k % 4));
			axi(1, 8'hB8, pm);
			axi(1, 8'hF8, pt);
			axi(1, 8'h00, m);
			wait_call(vec(pick(m, {pt[7:4], pm[6], pt[3:0], pm[5:0]})), 1);
			axi(1, 8'h00, 0);
			ret;
		end
		// level input: flag follows the pin, a dropped request is forgotten
		axi(1, 8'h04, 0);
		pin <= 2'h2;
		wait_call(16'h0003, 1);
		axi(0, 8'h00, 0);
		chk(q[0], 1, "level flag");
		pin <= 2'h3;
		repeat (8) @(posedge clk_sys_i);
		ret;
		wait_call(0, 0);
		tally_and_finish;
	end
endmodule
